// >>> tfb_host_reader.sv
// host reader model: tests the empty flag, then takes one word
// assumes one lane asked for at a time, same clock as the buffer
`timescale 1ns/1ps
module tfb_host_reader (
    input wire logic clk_sys, // clock
    input wire logic take, // keep reading
    input wire logic [1:0] lane, // lane to read
    input wire logic [2:0] output_empty_flag, // empty flags
    input wire logic [15:0] busOut, // bus data
    output logic [2:0] transferOut = 3'h0, // pop pulse
    output logic [2:0] readEnable, // bus select
    output logic [15:0] word = 16'h0000, // last word
    output logic got = 1'b0 // word taken
);
    assign readEnable = take ? 3'h1 << lane : 3'h0;
    always @(posedge clk_sys) begin
        transferOut <= 3'h0;
        got <= 1'b0;
        // wait a cycle after a pop so the flag is fresh again
        if (take && !output_empty_flag[lane] && !transferOut[lane]) begin
            transferOut <= 3'h1 << lane;
            word <= busOut;
            got <= 1'b1;
        end
    end
endmodule

// >>> tfb_monitor.sv
// checker on the result buffer ports
// assumes it is bound onto the buffer, one clock
`timescale 1ns/1ps
module tfb_monitor (
    input wire logic clk_sys, // clock
    input wire logic reset, // sync reset
    input wire logic master_clear, // clear
    input wire logic input_load_strobe, // load
    input wire logic [2:0] transferOut, // pops
    input wire logic [2:0] readEnable, // select
    input wire logic [2:0] output_empty_flag, // empty
    input wire logic [2:0] inputReady, // in free
    input wire logic [2:0] overflow, // lost load
    input wire logic [15:0] busOut, // bus data
    input wire logic busOe // bus drive
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_load_holds: assert property (input_load_strobe && !master_clear
        |=> inputReady == 3'h0) else $error("load not held");
    a_first_word: assert property (input_load_strobe && !master_clear &&
        output_empty_flag == 3'h7 && inputReady == 3'h7 ##1 !master_clear[*2]
        |=> output_empty_flag == 3'h0) else $error("first word late");
    a_bus_oe: assert property (busOe == (|readEnable))
        else $error("bus enable wrong");
    a_bus_idle: assert property (readEnable == 3'h0 |-> busOut == 16'h0)
        else $error("idle bus driven");
    a_clear_all: assert property (master_clear |=>
        output_empty_flag == 3'h7 && overflow == 3'h0) else $error("not clear");
    a_ovf_sticky: assert property (overflow[0] && !master_clear |=>
        overflow[0]) else $error("overflow dropped");
    a_ovf_cause: assert property (!overflow[0] ##1 overflow[0] |->
        $past(input_load_strobe) && !$past(inputReady[0]))
        else $error("overflow without lost load");
    a_empty_rise: assert property (!output_empty_flag[0] ##1
        output_empty_flag[0] |-> $past(transferOut[0]) || $past(master_clear))
        else $error("word vanished");
    a_word_holds: assert property (readEnable == 3'h1 &&
        !output_empty_flag[0] && !transferOut[0] && !master_clear ##1
        readEnable == 3'h1 |-> $stable(busOut)) else $error("word moved");
    c_overflow: cover property (overflow[0]);
    c_pop: cover property (transferOut[0] && !output_empty_flag[0]);
    c_clear: cover property (master_clear);
endmodule
bind tfb_triple_result_fifo tfb_monitor mon (.clk_sys, .reset, .master_clear,
    .input_load_strobe, .transferOut, .readEnable, .output_empty_flag,
    .inputReady, .overflow, .busOut, .busOe);

// >>> tfb_pkg.sv
// constants for the three-lane result buffer
// assumes one clock domain shared with the writer and the reader
package tfb_pkg;
    localparam int LANES = 3;
    localparam int WORD_W = 16;
    localparam int STAGE_DEPTH = 64;
    localparam int STAGE_W = 4;
    localparam int STAGES_DEEP = 4;
    localparam int STAGES_WIDE = WORD_W / STAGE_W;
    localparam int DEPTH = STAGE_DEPTH * STAGES_DEEP;
    localparam int PTR_W = 8;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] CNT_FULL = 9'h100;
    localparam logic [PTR_W-1:0] PTR_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam int LANE_TAP = 0;
    localparam int LANE_INPHASE = 1;
    localparam int LANE_QUAD = 2;
endpackage

// >>> tfb_triple_result_fifo.sv
// three independent first-in first-out lanes for correlator results
// assumes writer and reader share clk_sys; the reader enables at most
// one lane onto the shared bus at a time
`timescale 1ns/1ps
module tfb_triple_result_fifo (
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic reset, // synchronous, active high
    input wire logic master_clear, // empties all lanes
    input wire logic input_load_strobe, // loads all three lanes at once
    input wire logic [15:0] tapIndexIn, // tap index word
    input wire logic [15:0] inPhaseIn, // in-phase gain word
    input wire logic [15:0] quadIn, // quadrature gain word
    input wire logic [2:0] transferOut, // per-lane removal pulse
    input wire logic [2:0] readEnable, // per-lane bus enable
    output logic [2:0] output_empty_flag, // high when lane has no word out
    output logic [2:0] inputReady, // input holding register free
    output logic [2:0] overflow, // sticky, a load was lost
    output logic [15:0] busOut, // shared computer input bus data
    output logic busOe // high while a lane drives the bus
);
    logic [15:0] laneIn [tfb_pkg::LANES];
    logic [15:0] laneOut [tfb_pkg::LANES];

    // stack grid addressing: the upper pointer bits pick a row of
    // 64-deep stages, the low bits the entry inside that row
    localparam int ROW_W = $clog2(tfb_pkg::STAGES_DEEP);
    localparam int ENT_W = $clog2(tfb_pkg::STAGE_DEPTH);
    localparam int NIB = tfb_pkg::STAGE_W;

    function automatic logic [ROW_W-1:0] bankRow(
        input logic [tfb_pkg::PTR_W-1:0] ptr
    );
        return ROW_W'(ptr / tfb_pkg::STAGE_DEPTH);
    endfunction

    function automatic logic [ENT_W-1:0] bankEntry(
        input logic [tfb_pkg::PTR_W-1:0] ptr
    );
        return ENT_W'(ptr % tfb_pkg::STAGE_DEPTH);
    endfunction

    // pointers wrap at the full depth, so a plain 8-bit add is enough
    function automatic logic [tfb_pkg::PTR_W-1:0] ptrStep(
        input logic [tfb_pkg::PTR_W-1:0] ptr,
        input logic go
    );
        return go ? ptr + tfb_pkg::PTR_ONE : ptr;
    endfunction

    // a move in and a pop out in one cycle leave the fill level alone
    function automatic logic [tfb_pkg::CNT_W-1:0] countStep(
        input logic [tfb_pkg::CNT_W-1:0] cnt,
        input logic up,
        input logic down
    );
        logic [tfb_pkg::CNT_W-1:0] res;
        res = cnt;
        if (up && !down) begin
            res = cnt + tfb_pkg::CNT_ONE;
        end else if (!up && down) begin
            res = cnt - tfb_pkg::CNT_ONE;
        end
        return res;
    endfunction

    assign laneIn[tfb_pkg::LANE_TAP] = tapIndexIn;
    assign laneIn[tfb_pkg::LANE_INPHASE] = inPhaseIn;
    assign laneIn[tfb_pkg::LANE_QUAD] = quadIn;

    // identical lanes, no shared state between them
    for (genvar l = 0; l < tfb_pkg::LANES; l++) begin : gLane
        logic [15:0] stackWord;
        logic memWe;
        logic [15:0] inHold;
        logic [15:0] next_inHold;
        logic inFull;
        logic next_inFull;
        logic [15:0] outHold;
        logic [15:0] next_outHold;
        logic outFull;
        logic next_outFull;
        logic [tfb_pkg::PTR_W-1:0] wrPtr;
        logic [tfb_pkg::PTR_W-1:0] next_wrPtr;
        logic [tfb_pkg::PTR_W-1:0] rdPtr;
        logic [tfb_pkg::PTR_W-1:0] next_rdPtr;
        logic [tfb_pkg::CNT_W-1:0] count;
        logic [tfb_pkg::CNT_W-1:0] next_count;
        logic lost;
        logic next_lost;
        logic moveToStack;
        logic popToOut;

        // handshakes between the three parts of the lane
        always_comb begin
            moveToStack = inFull && (count != tfb_pkg::CNT_FULL);
            popToOut = (count != '0) &&
                (!outFull || transferOut[l]);
            // clear and reset restart the pointers, so no write then
            memWe = moveToStack && !master_clear && !reset;
        end

        // input holding register
        always_comb begin
            next_inHold = inHold;
            next_inFull = inFull && !moveToStack;
            next_lost = lost;
            if (input_load_strobe) begin
                // a load into a stuck register overwrites it only;
                // stack contents are never touched
                next_inHold = laneIn[l];
                next_inFull = 1'b1;
                if (inFull && !moveToStack) begin
                    next_lost = 1'b1;
                end
            end
            // clear wins over a load in the same cycle
            if (master_clear) begin
                next_inFull = 1'b0;
                next_lost = 1'b0;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                inHold <= tfb_pkg::WORD_RESET;
                inFull <= 1'b0;
                lost <= 1'b0;
            end else begin
                inHold <= next_inHold;
                inFull <= next_inFull;
                lost <= next_lost;
            end
        end

        // stack pointers and fill level
        always_comb begin
            next_wrPtr = ptrStep(wrPtr, moveToStack);
            next_rdPtr = ptrStep(rdPtr, popToOut);
            next_count = countStep(count, moveToStack, popToOut);
            if (master_clear) begin
                next_wrPtr = '0;
                next_rdPtr = '0;
                next_count = '0;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                wrPtr <= '0;
                rdPtr <= '0;
                count <= '0;
            end else begin
                wrPtr <= next_wrPtr;
                rdPtr <= next_rdPtr;
                count <= next_count;
            end
        end

        // output holding register
        always_comb begin
            next_outHold = popToOut ? stackWord : outHold;
            if (popToOut) begin
                next_outFull = 1'b1;
            end else if (transferOut[l]) begin
                next_outFull = 1'b0;
            end else begin
                next_outFull = outFull;
            end
            if (master_clear) begin
                next_outFull = 1'b0;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                outHold <= tfb_pkg::WORD_RESET;
                outFull <= 1'b0;
            end else begin
                outHold <= next_outHold;
                outFull <= next_outFull;
            end
        end

        // sixteen 64 x 4 banks, four rows deep by four nibbles wide;
        // no reset, the pointers alone say what is valid
        for (genvar c = 0; c < NIB; c++) begin : gCol
            logic [NIB-1:0] rowNib [tfb_pkg::STAGES_DEEP];
            for (genvar r = 0; r < tfb_pkg::STAGES_DEEP; r++) begin : gRow
                logic [NIB-1:0] bank [tfb_pkg::STAGE_DEPTH];
                always_ff @(posedge clk_sys) begin
                    if (memWe && bankRow(wrPtr) == ROW_W'(r)) begin
                        bank[bankEntry(wrPtr)] <= inHold[c*NIB +: NIB];
                    end
                end
                assign rowNib[r] = bank[bankEntry(rdPtr)];
            end
            assign stackWord[c*NIB +: NIB] = rowNib[bankRow(rdPtr)];
        end

        assign output_empty_flag[l] = !outFull;
        // ready lets a burst writer or a front card pace its loads
        assign inputReady[l] = !inFull;
        assign overflow[l] = lost;
        assign laneOut[l] = outHold;
    end

    // one-hot enable picks the lane; several enables give an OR
    // which the reader must avoid
    always_comb begin
        busOut = '0;
        for (int i = 0; i < tfb_pkg::LANES; i++) begin
            if (readEnable[i]) begin
                busOut = busOut | laneOut[i];
            end
        end
        busOe = |readEnable;
    end
endmodule

// >>> triple_result_fifo_buffer_bench.sv
// bench for the three-lane result buffer
// assumes the host reader model drives the read side
`timescale 1ns/1ps
module triple_result_fifo_buffer_bench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic master_clear = 1'b0;
    logic input_load_strobe = 1'b0;
    logic [15:0] tapIndexIn = 16'h0000;
    logic [15:0] inPhaseIn = 16'h0000;
    logic [15:0] quadIn = 16'h0000;
    logic [2:0] transferOut, readEnable, output_empty_flag, inputReady, overflow;
    logic [15:0] busOut, word;
    logic busOe, got;
    logic take = 1'b0;
    logic [1:0] lane = 2'h0;
    int err_total = 0;
    int check_count = 0;
    always #5 clk_sys = ~clk_sys;
    tfb_triple_result_fifo dut (.clk_sys, .reset, .master_clear,
        .input_load_strobe, .tapIndexIn, .inPhaseIn, .quadIn, .transferOut,
        .readEnable, .output_empty_flag, .inputReady, .overflow, .busOut, .busOe);
    tfb_host_reader host (.clk_sys, .take, .lane, .output_empty_flag, .busOut,
        .transferOut, .readEnable, .word, .got);
    task automatic chk(string what, logic [15:0] exp, logic [15:0] seen);
        check_count++;
        if (seen !== exp) begin
            $display("BAD %s exp %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask
    task automatic burst(int n);
        input_load_strobe <= 1'b1;
        for (int i = 0; i < n; i++) begin
            tapIndexIn <= 16'h1000 + 16'(i);
            inPhaseIn <= 16'h2000 + 16'(i);
            quadIn <= 16'h3000 + 16'(i);
            @(posedge clk_sys);
        end
        input_load_strobe <= 1'b0;
    endtask
    task automatic drain(int l, int n, logic [15:0] base);
        int w;
        take <= 1'b1;
        lane <= 2'(l);
        for (int i = 0; i < n; i++) begin
            w = 0;
            do begin
                @(posedge clk_sys);
                w++;
            end while (got !== 1'b1 && w < 50);
            chk("lane word", base + 16'(i), word);
        end
        take <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic test_order();
        burst(4);
        for (int l = 0; l < 3; l++) drain(l, 4, 16'h1000 * 16'(l + 1));
        chk("empty flags", 16'h0007, 16'(output_empty_flag));
        $display("order test done");
    endtask
    task automatic test_overflow();
        burst(260);
        @(posedge clk_sys);
        chk("overflow", 16'h0007, 16'(overflow));
        drain(0, 257, 16'h1000);
        master_clear <= 1'b1;
        @(posedge clk_sys);
        master_clear <= 1'b0;
        @(posedge clk_sys);
        chk("cleared", 16'h0770, {5'h0, output_empty_flag, 1'b0, inputReady,
            1'b0, overflow});
        $display("overflow test done");
    endtask
    task automatic test_paced();
        // writer thresholded below the depth: nothing may be lost
        burst(200);
        @(posedge clk_sys);
        chk("no overflow", 16'h0000, 16'(overflow));
        for (int l = 0; l < 3; l++)
            drain(l, 200, 16'h1000 * 16'(l + 1));
        chk("empty after", 16'h0007, 16'(output_empty_flag));
        $display("paced test done");
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        test_order();
        test_overflow();
        test_paced();
        close_out();
    end
    initial begin
        #100000;
        err_total++;
        close_out();
    end
endmodule
